//--- ppd_consts.vh
/*
 * Constants of the pin power-down hold block: widths, reset values,
 * state codes and the recovery timing.
 * Assumes a single 10 MHz clock; included by bare name, definitions only.
 */
`ifndef PPD_CONSTS_VH
`define PPD_CONSTS_VH

// Width of the user pin group frozen by power-down
`define PPD_IO_W 8

// Reset values of held pin data and enables
`define PPD_RST_DATA 8'h00
`define PPD_RST_OE 8'h00
`define PPD_RST_BIT 1'b0

// One-hot states of the power-down sequencer
`define PPD_ST_W 3
`define PPD_ST_RUN 3'h1
`define PPD_ST_DOWN 3'h2
`define PPD_ST_RECOV 3'h4

// Clock period in ns and longest allowed recovery in ns
`define PPD_CLK_NS 100
`define PPD_RECOV_NS 1000

// Recovery in clock cycles, rounded down as a longest time
`define PPD_RECOV_CYC (`PPD_RECOV_NS / `PPD_CLK_NS)

// Width of the recovery counter and its terminal value
`define PPD_RECOV_W 4
`define PPD_RECOV_LAST 4'h8

// Counter zero and step
`define PPD_CNT_ZERO 4'h0
`define PPD_CNT_ONE 4'h1

`endif

//--- ppd_ctrl_model.sv
/* External controller that drives the power-down pin.
   Assumes go_down is set by the bench in the mclk domain. */
`timescale 1ns/1ps
`default_nettype none
module ppd_ctrl_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic go_down,
    output logic pd_pin,
    output logic ready
);
    // Cycles counted since the pin went low
    logic [3:0] wait_q;
    // no use of the pin's array input
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pd_pin <= 1'h0;
            wait_q <= 4'hA;
        end else begin
            pd_pin <= go_down;
            if (go_down)
                wait_q <= 4'h0;
            else if (!pd_pin && wait_q != 4'hA)
                wait_q <= wait_q + 4'h1;
        end
    end
    // Fresh outputs trusted only after a full microsecond
    assign ready = !pd_pin && wait_q == 4'hA;
endmodule
`default_nettype wire

//--- ppd_hold.v
/*
 * Hold latch for a group of pin or logic signals: follows its data
 * while loaded, keeps the last value otherwise.
 * Assumes load is computed in the mclk domain by the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none

module ppd_hold #(
    parameter W = 8,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input wire mclk,
    input wire rst_n,
    input wire load,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    // Capture while loaded, hold the last level otherwise
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST;
        end else if (load) begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

//--- ppd_recov.v
/*
 * Recovery timer: counts the wake-up interval after the power-down
 * input returns low and flags the cycle in which it has run out.
 * Assumes start is a one-cycle pulse and run stays high while counting.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppd_consts.vh"

module ppd_recov (
    input wire mclk,
    input wire rst_n,
    input wire start,
    input wire run,
    output wire done
);

    // Recovery count since the power-down input fell
    reg [`PPD_RECOV_W-1:0] cnt_q;
    reg [`PPD_RECOV_W-1:0] cnt_d;

    // Next count: restart on start, step while running, else park
    always @* begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = `PPD_CNT_ZERO;
        end else if (run && (cnt_q != `PPD_RECOV_LAST)) begin
            cnt_d = cnt_q + `PPD_CNT_ONE;
        end
    end

    // Count register
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `PPD_CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Interval spent once the last value is held while still running
    assign done = run && !start && (cnt_q == `PPD_RECOV_LAST);

endmodule

`default_nettype wire

//--- ppd_top.v
/*
 * Pin-controlled power-down logic of a small programmable logic
 * device: freezes pins, array inputs and internal state while the
 * power-down input is high, then wakes up after a bounded interval.
 * Assumes the power-down input and all pins are synchronous to mclk
 * and that the option input is a static configuration level.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppd_consts.vh"

module ppd_top (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Configuration and the shared pin
    input wire pd_option_en,
    input wire power_down_input,
    output reg power_down_oe,
    output reg power_down_out,
    // User pin group and array side
    input wire [`PPD_IO_W-1:0] io_in,
    output wire [`PPD_IO_W-1:0] io_out,
    output wire [`PPD_IO_W-1:0] io_oe,
    output wire [`PPD_IO_W-1:0] core_in,
    input wire [`PPD_IO_W-1:0] core_out,
    input wire [`PPD_IO_W-1:0] core_oe,
    // Shared pin towards the array
    output reg core_pin_in,
    input wire core_pin_out,
    input wire core_pin_oe,
    // Macrocell terms behind the shared pin
    input wire mc_feedback_in,
    input wire mc_foldback_in,
    output reg mc_feedback_out,
    output reg mc_foldback_out,
    // Array clock enable and status
    output reg core_clk_en,
    output reg low_power,
    output reg awake
);

    // Sequencer state, one-hot
    reg [`PPD_ST_W-1:0] state_q;
    reg [`PPD_ST_W-1:0] state_d;

    // Option level as held by the configured logic
    reg option_q;

    // Power-down request as seen by the sequencer
    wire pd_req;

    // Recovery timer start, run and expiry
    wire recov_start;
    wire recov_run;
    wire recov_done;

    // Load enable shared by every hold latch
    wire hold_load;

    // Next state decides whether the array may run
    function is_run;
        input [`PPD_ST_W-1:0] st;
        begin
            is_run = (st == `PPD_ST_RUN);
        end
    endfunction

    // Frozen state with the input still high
    function is_down;
        input [`PPD_ST_W-1:0] st;
        begin
            is_down = (st == `PPD_ST_DOWN);
        end
    endfunction

    // Wake-up state, still frozen while the timer runs
    function is_recov;
        input [`PPD_ST_W-1:0] st;
        begin
            is_recov = (st == `PPD_ST_RECOV);
        end
    endfunction

    // Option level refreshed only while running, so a change
    // cannot slip in during a power-down interval
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            option_q <= `PPD_RST_BIT;
        end else if (is_run(state_q)) begin
            option_q <= pd_option_en;
        end
    end

    // A request without the option is ignored, so the pin stays
    // ordinary I/O (the shared-pin process below decides its use)
    // request counts only with the option set
    assign pd_req = option_q & power_down_input;

    // Next-state logic of the sequencer
    always @* begin
        state_d = state_q;
        case (state_q)
            // Normal operation
            `PPD_ST_RUN: begin
                if (pd_req) begin
                    state_d = `PPD_ST_DOWN;
                end
            end
            // Frozen and low-power
            `PPD_ST_DOWN: begin
                if (!power_down_input) begin
                    state_d = `PPD_ST_RECOV;
                end
            end
            // Waking up, still frozen
            `PPD_ST_RECOV: begin
                if (power_down_input) begin
                    // Input raised again before wake-up finished
                    state_d = `PPD_ST_DOWN;
                end else if (recov_done) begin
                    state_d = `PPD_ST_RUN;
                end
            end
            // Illegal code falls back to normal operation
            // (not reachable from reset, guards against upsets)
            default: begin
                state_d = `PPD_ST_RUN;
            end
        endcase
    end

    // State register
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= `PPD_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Timer starts on the falling input and runs through recovery
    assign recov_start = is_down(state_q) && is_recov(state_d);
    assign recov_run = is_recov(state_q);

    // Wake-up timeline, counted in mclk edges from the edge E0 that
    // samples the input low: E0 enters recovery and clears the count,
    // E1..E8 step it to its last value, and at E9 the sequencer returns
    // to running. E9 lies 900 ns after E0, inside the one-microsecond
    // budget even when the pin fell just after an edge.
    // A new rise during recovery parks the timer until the next fall.
    // Recovery interval timer
    ppd_recov u_recov (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(recov_start),
        .run(recov_run),
        .done(recov_done)
    );

    // latches load only when running next cycle
    assign hold_load = is_run(state_d);

    // All hold latches share one load enable. They load on every edge
    // whose next state is running, so the values in place when the input
    // was sampled high stay on the pins and on the array side until the
    // edge that ends recovery. The enable is a next-state term, so the
    // freeze takes effect on the same edge that enters power-down and no
    // input taken after that edge reaches the array.

    // array inputs sampled only while running
    // input hold latch keeps last level
    ppd_hold #(
        .W(`PPD_IO_W),
        .RST(`PPD_RST_DATA)
    ) u_hold_in (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(hold_load),
        .d(io_in),
        .q(core_in)
    );

    ppd_hold #(
        .W(`PPD_IO_W),
        .RST(`PPD_RST_DATA)
    ) u_hold_out (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(hold_load),
        .d(core_out),
        .q(io_out)
    );

    // output enables held, so high-z stays high-z
    ppd_hold #(
        .W(`PPD_IO_W),
        .RST(`PPD_RST_OE)
    ) u_hold_oe (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(hold_load),
        .d(core_oe),
        .q(io_oe)
    );

    // Shared pin: ordinary I/O without the option, control input with it
    // Loaded on the same edges as the pin group, so frozen alike
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            power_down_oe <= `PPD_RST_BIT;
            power_down_out <= `PPD_RST_BIT;
            core_pin_in <= `PPD_RST_BIT;
        end else if (hold_load) begin
            if (option_q) begin
                power_down_oe <= 1'b0;
                power_down_out <= 1'b0;
                // array input from the pin forced low
                core_pin_in <= 1'b0;
            end else begin
                // Ordinary bidirectional use of the pin
                power_down_oe <= core_pin_oe;
                power_down_out <= core_pin_out;
                core_pin_in <= power_down_input;
            end
        end
    end

    // Macrocell behind the shared pin keeps feeding the array
    // Frozen with the rest of the array inputs
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mc_feedback_out <= `PPD_RST_BIT;
            mc_foldback_out <= `PPD_RST_BIT;
        end else if (hold_load) begin
            mc_feedback_out <= mc_feedback_in;
            mc_foldback_out <= mc_foldback_in;
        end
    end

    // Array clock enable: low from the edge that enters power-down
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_clk_en <= 1'b1;
        end else begin
            // array registers frozen via clock enable
            core_clk_en <= is_run(state_d);
        end
    end

    // Low-power flag: high only in the frozen state, not in recovery
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_power <= 1'b0;
        end else begin
            low_power <= is_down(state_d);
        end
    end

    // Awake flag: raised together with the clock enable
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awake <= 1'b1;
        end else begin
            awake <= is_run(state_d);
        end
    end

endmodule

`default_nettype wire

//--- ppd_top_sva.sv
/* Port assertions for the power-down hold top.
   Assumes one mclk domain and an option level held static per reset. */
`timescale 1ns/1ps
`default_nettype none
`include "ppd_consts.vh"
module ppd_top_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pd_option_en,
    input wire logic power_down_input,
    input wire logic power_down_oe,
    input wire logic power_down_out,
    input wire logic [`PPD_IO_W-1:0] io_in,
    input wire logic [`PPD_IO_W-1:0] io_out,
    input wire logic [`PPD_IO_W-1:0] io_oe,
    input wire logic [`PPD_IO_W-1:0] core_in,
    input wire logic [`PPD_IO_W-1:0] core_out,
    input wire logic [`PPD_IO_W-1:0] core_oe,
    input wire logic core_pin_in,
    input wire logic core_pin_out,
    input wire logic core_pin_oe,
    input wire logic mc_feedback_in,
    input wire logic mc_foldback_in,
    input wire logic mc_feedback_out,
    input wire logic mc_foldback_out,
    input wire logic core_clk_en,
    input wire logic low_power,
    input wire logic awake
);
    // Option level as the block samples it
    logic opt_q;
    // Mirrors the sampled option register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            opt_q <= 1'h0;
        else
            opt_q <= pd_option_en;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_enter_down: assert property (
        opt_q && awake && power_down_input |=> low_power && !awake && !core_clk_en)
        else $error("power-down not entered");
    a_no_option: assert property (!opt_q && awake |=> !low_power)
        else $error("power-down without option");
    a_hold_down: assert property (low_power && power_down_input |=> low_power)
        else $error("left power-down early");
    a_out_freeze: assert property (!awake |-> $stable(io_out) && $stable(io_oe))
        else $error("outputs moved while frozen");
    a_in_block: assert property (
        !awake |-> $stable(core_in) && $stable(mc_feedback_out) && $stable(mc_foldback_out))
        else $error("inputs passed while frozen");
    a_live_path: assert property (
        awake && $past(rst_n) |-> io_out == $past(core_out) && io_oe == $past(core_oe)
        && core_in == $past(io_in))
        else $error("pins not live while running");
    a_macro_live: assert property (
        awake && $past(rst_n) |-> mc_feedback_out == $past(mc_feedback_in)
        && mc_foldback_out == $past(mc_foldback_in))
        else $error("macrocell terms not live");
    a_wake_time: assert property (
        $fell(low_power) |-> !awake [*8] ##1 !awake ##1 awake)
        else $error("wake-up time wrong");
    a_pin_given: assert property (
        opt_q && $past(opt_q) |-> !power_down_oe && !power_down_out && !core_pin_in)
        else $error("dedicated pin still ordinary");
    c_down: cover property (opt_q && awake && power_down_input);
    c_wake: cover property ($fell(low_power));
    c_plain: cover property (!opt_q && power_down_input);
endmodule
bind ppd_top ppd_top_sva u_sva (.*);
`default_nettype wire

//--- testbench.sv
/* Self-checking bench for the power-down hold top.
   Assumes the controller model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic opt = 1'h1;
    logic go_down = 1'h0;
    logic [7:0] io_in = 8'h00;
    logic [7:0] core_out = 8'h00;
    logic [7:0] core_oe = 8'h00;
    logic pin_o = 1'h1;
    logic fb = 1'h0;
    logic fo = 1'h0;
    wire pd_pin, ready, pd_oe, pd_out, cpin, fb_o, fo_o, clk_en, low_power, awake;
    wire [7:0] io_out, io_oe, core_in;
    int errors = 0;
    int checked = 0;
    ppd_ctrl_model u_ctrl (.mclk(mclk), .rst_n(rst_n), .go_down(go_down),
        .pd_pin(pd_pin), .ready(ready));
    ppd_top dut (.mclk(mclk), .rst_n(rst_n), .pd_option_en(opt),
        .power_down_input(pd_pin), .power_down_oe(pd_oe), .power_down_out(pd_out),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .core_in(core_in),
        .core_out(core_out), .core_oe(core_oe), .core_pin_in(cpin),
        .core_pin_out(pin_o), .core_pin_oe(pin_o), .mc_feedback_in(fb),
        .mc_foldback_in(fo), .mc_feedback_out(fb_o), .mc_foldback_out(fo_o),
        .core_clk_en(clk_en), .low_power(low_power), .awake(awake));
    // 10 MHz clock
    initial forever #50 mclk = ~mclk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Running pins follow the array one cycle later
    task automatic t_live;
        @(posedge mclk);
        core_out <= 8'h5A;
        core_oe <= 8'h0F;
        io_in <= 8'hC3;
        fb <= 1'h1;
        fo <= 1'h1;
        @(posedge mclk);
        @(negedge mclk);
        chk(io_out, 8'h5A);
        chk(io_oe, 8'h0F);
        chk(core_in, 8'hC3);
        chk({fb_o, fo_o}, 8'h03);
        chk({pd_oe, pd_out, cpin}, 8'h00);
    endtask
    // Freeze, change the pin group and macrocell inputs, then wake
    task automatic t_down;
        int i;
        @(posedge mclk);
        go_down <= 1'h1;
        for (i = 0; i < 5 && low_power !== 1'h1; i++)
            @(negedge mclk);
        @(posedge mclk);
        core_out <= 8'hA5;
        core_oe <= 8'hF0;
        io_in <= 8'h3C;
        fb <= 1'h0;
        fo <= 1'h0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk({low_power, clk_en, awake}, 8'h04);
        chk(io_out, 8'h5A);
        chk(io_oe, 8'h0F);
        chk(core_in, 8'hC3);
        chk({fb_o, fo_o}, 8'h03);
        @(posedge mclk);
        go_down <= 1'h0;
        for (i = 0; i < 20 && ready !== 1'h1; i++)
            @(negedge mclk);
        chk({low_power, clk_en, awake}, 8'h03);
        chk(io_out, 8'hA5);
        chk(core_in, 8'h3C);
    endtask
    // Without the option the pin does not power down
    task automatic t_plain;
        @(posedge mclk);
        rst_n <= 1'h0;
        opt <= 1'h0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        go_down <= 1'h1;
        repeat (4) @(posedge mclk);
        core_out <= 8'h81;
        @(posedge mclk);
        @(negedge mclk);
        chk({low_power, awake}, 8'h01);
        chk(io_out, 8'h81);
        chk({pd_oe, pd_out, cpin}, 8'h07);
        @(posedge mclk);
        go_down <= 1'h0;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (2) @(posedge mclk);
        t_live();
        t_down();
        t_plain();
        complete_run();
    end
    // Hang guard
    initial begin
        #50000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
